/* File: tw_pkg.sv */
// shared constants, states and carrier types of the two-wire slave
package tw_pkg;
    localparam int         TW_BITS      = 8;
    localparam logic [3:0] TW_LAST_BIT  = 4'h7;
    localparam logic [3:0] TW_BYTE_DONE = 4'h8;
    localparam logic [3:0] TW_CNT_ZERO  = 4'h0;
    localparam logic [3:0] TW_CNT_ONE   = 4'h1;
    localparam logic [6:0] TW_DEF_ADDR  = 7'h2a;
    localparam logic       TW_LINE_LOW  = 1'b0;
    localparam int         TW_RW_POS    = 0;

    typedef enum logic [3:0] {
        TW_S_IDLE     = 4'h0,
        TW_S_ADDR     = 4'h1,
        TW_S_ADDR_DEC = 4'h2,
        TW_S_HOLD     = 4'h3,
        TW_S_ACK      = 4'h4,
        TW_S_RX       = 4'h5,
        TW_S_RX_DEC   = 4'h6,
        TW_S_TX_WAIT  = 4'h7,
        TW_S_TX       = 4'h8,
        TW_S_TX_ACK   = 4'h9,
        TW_S_TX_AFT   = 4'ha,
        TW_S_IGNORE   = 4'hb
    } tw_state_t;

    // one received packet handed to the user side
    typedef struct packed {
        logic       is_addr;
        logic       rep;
        logic       rw;
        logic [7:0] data;
    } tw_ev_t;

    localparam int TW_EV_W = $bits(tw_ev_t);
endpackage

/* File: tw_sync.sv */
// two flip-flop synchroniser for levels
`timescale 1ns/1ps
module tw_sync
    import tw_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input  wire logic         clk,
    input  wire logic         rst,
    // level in and synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
        end else begin
            meta_reg <= d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg <= '0;
        end else begin
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule

/* File: tw_hs.sv */
// toggle handshake carrying one word between two clock domains
`timescale 1ns/1ps
module tw_hs
    import tw_pkg::*;
#(
    parameter int W = 8
) (
    // source domain
    input  wire logic         s_clk,
    input  wire logic         s_rst,
    input  wire logic         s_valid,
    output logic              s_ready,
    input  wire logic [W-1:0] s_data,
    // destination domain
    input  wire logic         d_clk,
    input  wire logic         d_rst,
    output logic              d_valid,
    input  wire logic         d_ready,
    output logic      [W-1:0] d_data
);
    logic         req_reg;
    logic         ack_reg;
    logic [W-1:0] data_reg;
    logic         req_d;
    logic         ack_s;

    tw_sync #(.W(1)) u_req (.clk(d_clk), .rst(d_rst), .d(req_reg), .q(req_d));
    tw_sync #(.W(1)) u_ack (.clk(s_clk), .rst(s_rst), .d(ack_reg), .q(ack_s));

    // word held stable until the far side answers, so it crosses unsynchronised
    assign s_ready = (req_reg == ack_s);
    assign d_valid = (req_d != ack_reg);
    assign d_data  = data_reg;

    always_ff @(posedge s_clk) begin
        if (s_rst) begin
            req_reg <= 1'b0;
        end else if (s_valid && s_ready) begin
            req_reg <= ~req_reg;
        end
    end

    always_ff @(posedge s_clk) begin
        if (s_rst) begin
            data_reg <= '0;
        end else if (s_valid && s_ready) begin
            data_reg <= s_data;
        end
    end

    always_ff @(posedge d_clk) begin
        if (d_rst) begin
            ack_reg <= 1'b0;
        end else if (d_valid && d_ready) begin
            ack_reg <= ~ack_reg;
        end
    end
endmodule

/* File: tw_slave.sv */
// two-wire interface unit, slave side, with clock stretching
//
// What this block does
// - master clocks; anyone may stretch clock low
// - start: data falls while clock high
// - stop: data rises while clock high
// - start without preceding stop is repeated
// - data changes only while clock low
// - eight bits MSB first, then acknowledge
// - receiver acknowledges low in ninth clock
// - after start, master sends address and direction
// - matching slave acknowledges; others stay released
// - one address packet per start
// - direction low: master writes data
// - direction high: slave sends data
`timescale 1ns/1ps
module tw_slave
    import tw_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR = TW_DEF_ADDR
) (
    // system clock domain
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // link clock, samples the bus lines
    input  wire logic       bus_clk,
    // clock line
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    // data line
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // bytes to send on master reads
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    // received packets
    output logic            ev_valid,
    input  wire logic       ev_ready,
    output tw_ev_t          ev,
    // transaction in progress
    output logic            tw_active
);
    ////////////////////////////////////////////////////////////////////////
    logic      bus_rst;
    logic      scl_s;
    logic      sda_s;
    logic      scl_q_reg;
    logic      sda_q_reg;
    tw_state_t st_reg;
    tw_state_t st_next;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    logic      sda_oe_reg;
    logic      scl_oe_reg;
    logic      is_addr_reg;
    logic      rw_reg;
    logic      rep_reg;
    logic      act_reg;
    logic      mack_reg;
    logic      scl_rise;
    logic      scl_fall;
    logic      start_det;
    logic      stop_det;
    logic      addr_hit;
    logic      bit_st;
    logic      ev_v_b;
    logic      ev_r_b;
    tw_ev_t    ev_b;
    logic      tx_v_b;
    logic      tx_r_b;
    logic [7:0] tx_d_b;
    logic [TW_EV_W-1:0] ev_raw;

    ////////////////////////////////////////////////////////////////////////
    // crossings
    tw_sync #(.W(1)) u_rst (.clk(bus_clk), .rst(1'b0), .d(sys_rst), .q(bus_rst));
    // line syncs follow the pins through reset so no false edge follows release
    tw_sync #(.W(1)) u_scl (.clk(bus_clk), .rst(1'b0), .d(scl_i), .q(scl_s));
    tw_sync #(.W(1)) u_sda (.clk(bus_clk), .rst(1'b0), .d(sda_i), .q(sda_s));
    tw_sync #(.W(1)) u_act (.clk(clk), .rst(sys_rst), .d(act_reg), .q(tw_active));

    tw_hs #(.W(TW_BITS)) u_tx (
        .s_clk   (clk),
        .s_rst   (sys_rst),
        .s_valid (tx_valid),
        .s_ready (tx_ready),
        .s_data  (tx_data),
        .d_clk   (bus_clk),
        .d_rst   (bus_rst),
        .d_valid (tx_v_b),
        .d_ready (tx_r_b),
        .d_data  (tx_d_b)
    );

    tw_hs #(.W(TW_EV_W)) u_ev (
        .s_clk   (bus_clk),
        .s_rst   (bus_rst),
        .s_valid (ev_v_b),
        .s_ready (ev_r_b),
        .s_data  (ev_b),
        .d_clk   (clk),
        .d_rst   (sys_rst),
        .d_valid (ev_valid),
        .d_ready (ev_ready),
        .d_data  (ev_raw)
    );

    assign ev = tw_ev_t'(ev_raw);

    ////////////////////////////////////////////////////////////////////////
    // line conditions
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_q_reg;
    assign scl_fall  = ~scl_s & scl_q_reg;
    assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    assign stop_det  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
    assign addr_hit  = (sh_reg[7:1] == OWN_ADDR);
    assign bit_st    = (st_reg == TW_S_ADDR) || (st_reg == TW_S_RX) || (st_reg == TW_S_TX);

    // packet waits here until the user side can take it, clock held low
    assign ev_v_b = (st_reg == TW_S_HOLD);
    assign ev_b   = '{is_addr: is_addr_reg, rep: rep_reg, rw: rw_reg, data: sh_reg};
    assign tx_r_b = (st_reg == TW_S_TX_WAIT);

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        st_next = st_reg;
        if (start_det) begin
            st_next = TW_S_ADDR;
        end else if (stop_det) begin
            st_next = TW_S_IDLE;
        end else begin
            case (st_reg)
                TW_S_IDLE: st_next = TW_S_IDLE;
                TW_S_ADDR: begin
                    if (scl_rise && cnt_reg == TW_LAST_BIT) begin
                        st_next = TW_S_ADDR_DEC;
                    end
                end
                TW_S_ADDR_DEC: begin
                    if (scl_fall) begin
                        st_next = addr_hit ? TW_S_HOLD : TW_S_IGNORE;
                    end
                end
                TW_S_HOLD: begin
                    if (ev_r_b) begin
                        st_next = TW_S_ACK;
                    end
                end
                TW_S_ACK: begin
                    if (scl_fall) begin
                        st_next = (is_addr_reg && rw_reg) ? TW_S_TX_WAIT : TW_S_RX;
                    end
                end
                TW_S_RX: begin
                    if (scl_rise && cnt_reg == TW_LAST_BIT) begin
                        st_next = TW_S_RX_DEC;
                    end
                end
                TW_S_RX_DEC: begin
                    if (scl_fall) begin
                        st_next = TW_S_HOLD;
                    end
                end
                TW_S_TX_WAIT: begin
                    if (tx_v_b) begin
                        st_next = TW_S_TX;
                    end
                end
                TW_S_TX: begin
                    if (scl_fall && cnt_reg == TW_BYTE_DONE) begin
                        st_next = TW_S_TX_ACK;
                    end
                end
                TW_S_TX_ACK: begin
                    if (scl_rise) begin
                        st_next = TW_S_TX_AFT;
                    end
                end
                TW_S_TX_AFT: begin
                    if (scl_fall) begin
                        st_next = mack_reg ? TW_S_TX_WAIT : TW_S_IGNORE;
                    end
                end
                TW_S_IGNORE: st_next = TW_S_IGNORE;
                default: st_next = TW_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            st_reg <= TW_S_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit counter and shifter
    always_ff @(posedge bus_clk) begin
        if (bus_rst || start_det) begin
            cnt_reg <= TW_CNT_ZERO;
        end else if (scl_rise && bit_st) begin
            cnt_reg <= cnt_reg + TW_CNT_ONE;
        end else if (st_reg == TW_S_ACK || st_reg == TW_S_TX_WAIT) begin
            cnt_reg <= TW_CNT_ZERO;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            sh_reg <= '0;
        end else if (scl_rise && (st_reg == TW_S_ADDR || st_reg == TW_S_RX)) begin
            sh_reg <= {sh_reg[6:0], sda_s};
        end else if (st_reg == TW_S_TX_WAIT && tx_v_b) begin
            sh_reg <= {tx_d_b[6:0], 1'b0};
        end else if (st_reg == TW_S_TX && scl_fall) begin
            sh_reg <= {sh_reg[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line drivers: only ever pull low
    always_ff @(posedge bus_clk) begin
        if (bus_rst || start_det || stop_det) begin
            sda_oe_reg <= 1'b0;
        end else if (st_reg == TW_S_HOLD && ev_r_b) begin
            sda_oe_reg <= 1'b1;
        end else if (st_reg == TW_S_ACK && scl_fall) begin
            sda_oe_reg <= 1'b0;
        end else if (st_reg == TW_S_TX_WAIT && tx_v_b) begin
            sda_oe_reg <= ~tx_d_b[7];
        end else if (st_reg == TW_S_TX && scl_fall) begin
            sda_oe_reg <= (cnt_reg == TW_BYTE_DONE) ? 1'b0 : ~sh_reg[7];
        end
    end

    // stretch while a packet or a byte to send is pending
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            scl_oe_reg <= 1'b0;
        end else begin
            scl_oe_reg <= (st_next == TW_S_HOLD) || (st_next == TW_S_TX_WAIT);
        end
    end

    assign scl_o  = TW_LINE_LOW;
    assign sda_o  = TW_LINE_LOW;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // transaction flags
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            is_addr_reg <= 1'b0;
        end else if (start_det) begin
            is_addr_reg <= 1'b1;
        end else if (st_reg == TW_S_ACK && scl_fall) begin
            is_addr_reg <= 1'b0;
        end
    end
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            rw_reg <= 1'b0;
        end else if (st_reg == TW_S_ADDR_DEC && scl_fall) begin
            rw_reg <= sh_reg[TW_RW_POS];
        end
    end
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            rep_reg <= 1'b0;
        end else if (start_det) begin
            rep_reg <= act_reg;
        end
    end
    always_ff @(posedge bus_clk) begin
        if (bus_rst || stop_det) begin
            act_reg <= 1'b0;
        end else if (start_det) begin
            act_reg <= 1'b1;
        end
    end
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            mack_reg <= 1'b0;
        end else if (st_reg == TW_S_TX_ACK && scl_rise) begin
            mack_reg <= ~sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge bus_clk); endclocking
    default disable iff (bus_rst);

    property p_stretch_only_waiting;
        scl_oe |-> (st_reg == TW_S_HOLD || st_reg == TW_S_TX_WAIT);
    endproperty
    a_stretch_only_waiting: assert property (p_stretch_only_waiting)
        else $error("clock held low outside a wait state");
    property p_start_to_addr;
        start_det |=> (st_reg == TW_S_ADDR && cnt_reg == TW_CNT_ZERO && rep_reg == $past(act_reg));
    endproperty
    a_start_to_addr: assert property (p_start_to_addr)
        else $error("start did not open an address packet");
    property p_stop_release;
        (stop_det && !start_det) |=> (st_reg == TW_S_IDLE && !sda_oe && !act_reg);
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("stop did not release the bus");
    property p_drive_on_low;
        $rose(sda_oe) |-> !scl_s;
    endproperty
    a_drive_on_low: assert property (p_drive_on_low)
        else $error("data pulled low while clock high");
    property p_eight_bits;
        (st_reg == TW_S_ADDR && scl_rise && cnt_reg == TW_LAST_BIT && !start_det && !stop_det)
            |=> (st_reg == TW_S_ADDR_DEC);
    endproperty
    a_eight_bits: assert property (p_eight_bits)
        else $error("address byte not closed after eight bits");
    property p_ack_held;
        (st_reg == TW_S_ACK) |-> sda_oe;
    endproperty
    a_ack_held: assert property (p_ack_held)
        else $error("acknowledge not driven low");
    property p_ignore_other;
        (st_reg == TW_S_ADDR_DEC && scl_fall && !addr_hit && !start_det && !stop_det)
            |=> (st_reg == TW_S_IGNORE) ##1 !sda_oe;
    endproperty
    a_ignore_other: assert property (p_ignore_other)
        else $error("foreign address not ignored");
    property p_ignore_until_start;
        (st_reg == TW_S_IGNORE && !start_det) |=> (st_reg inside {TW_S_IGNORE, TW_S_IDLE});
    endproperty
    a_ignore_until_start: assert property (p_ignore_until_start)
        else $error("left ignore without a start");
    property p_write_dir;
        (st_reg == TW_S_ACK && scl_fall && is_addr_reg && !rw_reg && !start_det && !stop_det)
            |=> (st_reg == TW_S_RX);
    endproperty
    a_write_dir: assert property (p_write_dir)
        else $error("write address not followed by receive");
    property p_read_dir;
        (st_reg == TW_S_ACK && scl_fall && is_addr_reg && rw_reg && !start_det && !stop_det)
            |=> (st_reg == TW_S_TX_WAIT && scl_oe);
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("read address not followed by send");
    c_read_hit: cover property (st_reg == TW_S_ACK && is_addr_reg && rw_reg);
    c_write_byte: cover property (st_reg == TW_S_RX_DEC ##[1:200] st_reg == TW_S_ACK);
    c_rep_start: cover property (start_det && act_reg);
    c_master_nack: cover property (st_reg == TW_S_TX_AFT && !mack_reg);
endmodule

/* File: tw_master.sv */
// behavioural bus master facing the two-wire slave
`timescale 1ns/1ps
module tw_master
    import tw_pkg::*;
#(
    parameter int QTR_NS = 1000
) (
    // wired line levels
    input  wire logic scl,
    input  wire logic sda,
    // pull-low enables, never drive high
    output logic      scl_m_oe,
    output logic      sda_m_oe
);
    initial begin
        scl_m_oe = 1'b0;
        sda_m_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // release waits out any stretch, giving up after 20000 polls of 50 ns so a stuck line cannot hang the task
    task automatic set_scl(input logic rel);
        int n;
        scl_m_oe = ~rel;
        n = 0;
        while (rel && scl !== 1'b1 && n < 20000) begin
            #50;
            n++;
        end
        #(QTR_NS);
    endtask

    // data set up only while the clock is low
    task automatic clock_bit(input logic b, output logic s);
        sda_m_oe = ~b;
        #(QTR_NS);
        set_scl(1'b1);
        s = sda;
        set_scl(1'b0);
    endtask

    // works from idle and as a repeated start
    task automatic start();
        sda_m_oe = 1'b0;
        #(QTR_NS);
        set_scl(1'b1);
        sda_m_oe = 1'b1;
        #(QTR_NS);
        set_scl(1'b0);
    endtask

    task automatic stop();
        sda_m_oe = 1'b1;
        #(QTR_NS);
        set_scl(1'b1);
        sda_m_oe = 1'b0;
        #(QTR_NS);
    endtask

    // write: tx byte, ack_out 1; read: tx ff, ack_out 0 to acknowledge
    task automatic xfer(input logic [7:0] tx, input logic ack_out,
                        output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= 0; i--) begin
            clock_bit(tx[i], rx[i]);
        end
        clock_bit(ack_out, ack_in);
        sda_m_oe = 1'b0;
    endtask
endmodule

/* File: tw_slave_bench.sv */
// self-checking bench for the two-wire slave
`timescale 1ns/1ps
module tw_slave_bench
    import tw_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h51;

    logic   clk, bus_clk, sys_rst, tx_valid, ev_ready, tx_ready, ev_valid, tw_active;
    logic   scl_o, scl_oe, sda_o, sda_oe, scl_m_oe, sda_m_oe, oe_seen, scl_q, sda_oe_q;
    logic   [7:0] tx_data;
    tw_ev_t ev;
    int     miscompares, samples_checked;
    wire logic scl = ~(scl_oe | scl_m_oe);
    wire logic sda = ~(sda_oe | sda_m_oe);

    tw_slave #(.OWN_ADDR(ADDR)) dut (
        .clk(clk), .sys_rst(sys_rst), .bus_clk(bus_clk),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .ev_valid(ev_valid), .ev_ready(ev_ready), .ev(ev), .tw_active(tw_active)
    );

    tw_master #(.QTR_NS(1000)) m (
        .scl(scl), .sda(sda), .scl_m_oe(scl_m_oe), .sda_m_oe(sda_m_oe)
    );

    always #10 clk = ~clk;
    always #62.5 bus_clk = ~bus_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // line watch on the link clock
    always @(posedge bus_clk) begin
        scl_q <= scl;
        sda_oe_q <= sda_oe;
        if (scl_oe || sda_oe) oe_seen <= 1'b1;
        if (!sys_rst && scl_q && scl && sda_oe !== sda_oe_q) chk("sda_still", 11'(sda_oe_q), 11'(sda_oe));
        if ((scl_oe && scl_o !== 1'b0) || (sda_oe && sda_o !== 1'b0)) chk("pull_low", 11'h001, 11'h000);
    end

    task automatic take_ev(input tw_ev_t exp);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ev_valid !== 1'b1 && n < 20000);
        chk("ev", ev, exp);
        ev_ready = 1'b1;
        @(posedge clk);
        #1 ev_ready = 1'b0;
    endtask

    task automatic send_tx(input logic [7:0] b);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tx_ready !== 1'b1 && n < 20000);
        tx_valid = 1'b1;
        tx_data = b;
        @(posedge clk);
        #1 tx_valid = 1'b0;
        @(posedge clk);
        #1 chk("tx_busy", 11'(tx_ready), 11'h000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_write();
        logic [7:0] d;
        logic a;
        fork
            begin
                m.start();
                m.xfer({ADDR, 1'b0}, 1'b1, d, a);
                chk("addr_ack", 11'(a), 11'h000);
                m.xfer(8'h4b, 1'b1, d, a);
                chk("data_ack", 11'(a), 11'h000);
                chk("active", 11'(tw_active), 11'h001);
                m.stop();
            end
            begin
                take_ev('{1'b1, 1'b0, 1'b0, {ADDR, 1'b0}});
                take_ev('{1'b0, 1'b0, 1'b0, 8'h4b});
            end
        join
        repeat (8) @(posedge clk);
        chk("idle", 11'(tw_active), 11'h000);
        $display("write test done");
    endtask

    task automatic t_foreign();
        logic [7:0] d;
        logic a;
        m.start();
        oe_seen = 1'b0;
        m.xfer({7'h15, 1'b0}, 1'b1, d, a);
        chk("nack", 11'(a), 11'h001);
        m.xfer(8'h00, 1'b1, d, a);
        m.stop();
        chk("released", 11'(oe_seen), 11'h000);
        chk("no_event", 11'(ev_valid), 11'h000);
        $display("foreign address test done");
    endtask

    task automatic t_read();
        logic [7:0] d;
        logic a;
        fork
            begin
                m.start();
                m.xfer({ADDR, 1'b0}, 1'b1, d, a);
                m.start();
                m.xfer({ADDR, 1'b1}, 1'b1, d, a);
                chk("rd_addr_ack", 11'(a), 11'h000);
                m.xfer(8'hff, 1'b0, d, a);
                chk("rd_byte0", 11'(d), 11'h01e);
                m.xfer(8'hff, 1'b1, d, a);
                chk("rd_byte1", 11'(d), 11'h0c5);
                m.stop();
            end
            begin
                take_ev('{1'b1, 1'b0, 1'b0, {ADDR, 1'b0}});
                take_ev('{1'b1, 1'b1, 1'b1, {ADDR, 1'b1}});
                send_tx(8'h1e);
                send_tx(8'hc5);
            end
        join
        repeat (8) @(posedge clk);
        chk("tx_free", 11'(tx_ready), 11'h001);
        $display("repeated start read test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the three tests need well under 1 ms of bus time
    initial begin
        #1_500_000;
        miscompares++;
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        bus_clk = 1'b0;
        sys_rst = 1'b1;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        ev_ready = 1'b0;
        oe_seen = 1'b0;
        scl_q = 1'b1;
        sda_oe_q = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        // 16 cycles still give the link side two reset edges
        repeat (16) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (40) @(posedge clk);
        #1 chk("reset", {6'h00, scl_oe, sda_oe, tx_ready, ev_valid, tw_active}, 11'h004);
        t_write();
        t_foreign();
        t_read();
        end_of_test();
    end
endmodule
